/* rtl/udc_counter.sv */
/*
 * Four-bit reversible binary counter with separate up and down count clocks,
 * parallel preset, master clear and cascadable carry and borrow outputs.
 * Assumes all pin inputs are asynchronous to CLK and are oversampled by it;
 * each count clock level must last at least two CLK periods.
 */
`timescale 1ns/10ps

module udc_counter
   import udc_pkg::*;
(
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             RSTN,
   // Count clocks
   input  wire logic             COUNT_UP_CLOCK,
   input  wire logic             COUNT_DOWN_CLOCK,
   // Controls
   input  wire logic             LOAD_N,
   input  wire logic             MASTER_CLEAR,
   input  wire logic [CNT_W-1:0] PRESET_INPUTS,
   // Count and cascade outputs
   output logic      [CNT_W-1:0] COUNT_OUTPUTS,
   output logic                  CARRY_OUT_N,
   output logic                  BORROW_OUT_N
);

   // ==========================================================
   // Input synchronisation
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic              up_s;
   logic              dn_s;
   logic              clr_s;
   logic              ld_n_s;
   logic [CNT_W-1:0]  preset_s;

   assign pins_raw = {COUNT_UP_CLOCK, COUNT_DOWN_CLOCK, MASTER_CLEAR, LOAD_N, PRESET_INPUTS};

   udc_sync #(
      .WIDTH   (SYNC_W),
      .RST_VAL (SYNC_RST)
   ) udc_sync_inst (
      .clk  (CLK),
      .rstn (RSTN),
      .d    (pins_raw),
      .q    (pins_s)
   );

   assign up_s     = pins_s[POS_UP];
   assign dn_s     = pins_s[POS_DN];
   assign clr_s    = pins_s[POS_CLR];
   assign ld_n_s   = pins_s[POS_LDN];
   assign preset_s = pins_s[CNT_W-1:0];

   // ==========================================================
   // Edge detection
   // History runs through clear and load, so a clock held low across them
   // still yields a countable rising edge afterwards.
   logic up_prev_r;
   logic dn_prev_r;
   logic up_rise;
   logic dn_rise;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         up_prev_r <= CLK_IDLE;
         dn_prev_r <= CLK_IDLE;
      end else begin
         up_prev_r <= up_s;
         dn_prev_r <= dn_s;
      end
   end

   assign up_rise = up_s & ~up_prev_r;
   assign dn_rise = dn_s & ~dn_prev_r;

   // ==========================================================
   // Operation select
   // An edge with the other clock low, or both rising at once, is dropped:
   // the driver must not do that, and dropping is the safe outcome.
   logic      up_ok;
   logic      dn_ok;
   udc_mode_t mode;

   assign up_ok = up_rise & dn_s & ~dn_rise;
   assign dn_ok = dn_rise & up_s & ~up_rise;
   assign mode  = clr_s   ? UDC_CLEAR :
                  !ld_n_s ? UDC_LOAD  :
                  up_ok   ? UDC_UP    :
                  dn_ok   ? UDC_DOWN  :
                            UDC_HOLD;

   // ==========================================================
   // Count state
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic             carry_r;
   logic             carry_nxt;
   logic             borrow_r;
   logic             borrow_nxt;

   always_comb begin
      case (mode)
         UDC_CLEAR: count_nxt = CNT_ZERO;
         UDC_LOAD:  count_nxt = preset_s;
         UDC_UP:    count_nxt = count_r + CNT_STEP;
         UDC_DOWN:  count_nxt = count_r - CNT_STEP;
         default:   count_nxt = count_r;
      endcase
   end

   // Terminal flags follow the clock level, so they mirror its waveform
   assign carry_nxt  = ~((count_nxt == CNT_MAX) & ~up_s);
   assign borrow_nxt = ~((count_nxt == CNT_ZERO) & ~dn_s);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         count_r  <= CNT_ZERO;
         carry_r  <= TC_IDLE;
         borrow_r <= TC_IDLE;
      end else begin
         count_r  <= count_nxt;
         carry_r  <= carry_nxt;
         borrow_r <= borrow_nxt;
      end
   end

   assign COUNT_OUTPUTS = count_r;
   assign CARRY_OUT_N   = carry_r;
   assign BORROW_OUT_N  = borrow_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   clear_zero_a: assert property (
      clr_s |=> (count_r == CNT_ZERO))
      else $error("count not zero after clear");

   clear_prio_a: assert property (
      (clr_s && !ld_n_s && preset_s != CNT_ZERO) |=> (count_r == CNT_ZERO))
      else $error("load beat clear");

   load_copy_a: assert property (
      (!clr_s && !ld_n_s) |=> (count_r == $past(preset_s)))
      else $error("preset not copied");

   count_up_a: assert property (
      (!clr_s && ld_n_s && up_rise && dn_s && !dn_rise)
         |=> (count_r == $past(count_r) + CNT_STEP))
      else $error("up count wrong");

   count_down_a: assert property (
      (!clr_s && ld_n_s && dn_rise && up_s && !up_rise)
         |=> (count_r == $past(count_r) - CNT_STEP))
      else $error("down count wrong");

   wrap_up_a: assert property (
      (count_r == CNT_MAX && mode == UDC_UP) |=> (count_r == CNT_ZERO))
      else $error("no wrap to zero");

   wrap_down_a: assert property (
      (count_r == CNT_ZERO && mode == UDC_DOWN) |=> (count_r == CNT_MAX))
      else $error("no wrap to fifteen");

   count_hold_a: assert property (
      (ld_n_s && !clr_s && !up_rise && !dn_rise) |=> $stable(count_r))
      else $error("count moved without cause");

   carry_low_a: assert property (
      !carry_r |-> (count_r == CNT_MAX && !up_prev_r))
      else $error("carry low off terminal count");

   carry_high_a: assert property (
      (count_r == CNT_MAX && up_prev_r) |-> carry_r)
      else $error("carry low with up clock high");

   borrow_low_a: assert property (
      !borrow_r |-> (count_r == CNT_ZERO && !dn_prev_r))
      else $error("borrow low off zero");

   borrow_clear_a: assert property (
      (clr_s && !dn_s) |=> !borrow_r)
      else $error("borrow not low during clear");

   borrow_high_a: assert property (
      (count_r == CNT_ZERO && dn_prev_r) |-> borrow_r)
      else $error("borrow low with down clock high");

   carry_load_a: assert property (
      (!clr_s && !ld_n_s && preset_s == CNT_MAX && !up_s) |=> !carry_r)
      else $error("carry not low on loaded fifteen");

   clear_carry_a: assert property (
      clr_s |=> carry_r)
      else $error("carry low during clear");

   // Up clock held low through load, released, then raised four cycles later
   relaunch_a: assert property (
      (!ld_n_s && !clr_s && !up_s && dn_s)
         ##1 (ld_n_s && !clr_s && !up_s && dn_s) [*4]
         ##1 (ld_n_s && !clr_s && up_s && dn_s)
         |=> (count_r == $past(count_r) + CNT_STEP))
      else $error("edge after load lost");

   up_seen_c:     cover property (mode == UDC_UP ##[1:20] mode == UDC_UP);
   down_wrap_c:   cover property (count_r == CNT_ZERO && mode == UDC_DOWN);
   carry_pulse_c: cover property (carry_r ##1 !carry_r ##[1:10] carry_r);
   load_then_c:   cover property (mode == UDC_LOAD ##[1:10] mode == UDC_DOWN);

endmodule

/* pkg/udc_pkg.sv */
/*
 * Constants and types for the four-bit up/down counter.
 * Assumes a single system clock; count clocks and controls arrive as pins.
 */
package udc_pkg;

   // ==========================================================
   // Widths and values
   localparam int unsigned CNT_W   = 4;
   localparam int unsigned CTRL_W  = 4;
   localparam int unsigned SYNC_W  = CNT_W + CTRL_W;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_MAX  = 4'hf;
   localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

   // ==========================================================
   // Synchroniser bit positions and reset levels
   localparam int unsigned POS_UP   = 7;
   localparam int unsigned POS_DN   = 6;
   localparam int unsigned POS_CLR  = 5;
   localparam int unsigned POS_LDN  = 4;
   // Idle levels: both clocks high, load released, clear released
   localparam logic [SYNC_W-1:0] SYNC_RST = 8'hd0;
   localparam logic              TC_IDLE  = 1'h1;
   localparam logic              CLK_IDLE = 1'h1;

   // ==========================================================
   // Operation selected each cycle
   typedef enum logic [4:0] {
      UDC_HOLD  = 5'h01,
      UDC_UP    = 5'h02,
      UDC_DOWN  = 5'h04,
      UDC_LOAD  = 5'h08,
      UDC_CLEAR = 5'h10
   } udc_mode_t;

endpackage

/* rtl/udc_sync.sv */
/*
 * Two-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is an unrelated level; no bus coherency is given.
 */
`timescale 1ns/10ps
module udc_sync #(
   parameter int unsigned       WIDTH   = 8,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

/* tb/udc_partner.sv */
/*
 * Partner model: control logic driving the two count clocks.
 * Assumes the bench calls drive() just after a falling CLK edge.
 */
`timescale 1ns/10ps
module udc_partner (
   // Count clock pins
   output logic up_clk,
   output logic dn_clk
);
   // ==========================================================
   // Idle level high, so the other clock can count
   initial begin
      up_clk = 1'h1;
      dn_clk = 1'h1;
   end

   // ==========================================================
   // Only the named clock moves; reversal happens with both high
   task automatic drive(input bit up, input bit lvl);
      if (up) begin
         up_clk = lvl;
      end else begin
         dn_clk = lvl;
      end
   endtask
endmodule

/* tb/up_down_binary_counter_4bit_tb_top.sv */
/*
 * Self-checking bench for the up/down counter, with an integer model.
 * Assumes the 3-edge pin-to-output latency; waits of 4 cycles cover it.
 */
`timescale 1ns/10ps
module up_down_binary_counter_4bit_tb_top import udc_pkg::*; ();
   // ==========================================================
   // Signals
   logic             clk      = 1'h0;
   logic             rstn     = 1'h0;
   logic             load_n   = 1'h1;
   logic             clear    = 1'h0;
   logic [CNT_W-1:0] preset   = 4'h0;
   logic             up_clk;
   logic             dn_clk;
   logic [CNT_W-1:0] cnt;
   logic             carry_n;
   logic             borrow_n;
   int               n_fail      = 0;
   int               checks_done = 0;
   int               seed        = 32'h914bc8af;
   int               m           = 0;

   always #50 clk = ~clk;

   udc_partner udc_partner_inst (.up_clk(up_clk), .dn_clk(dn_clk));

   udc_counter udc_counter_inst (
      .CLK(clk), .RSTN(rstn), .COUNT_UP_CLOCK(up_clk), .COUNT_DOWN_CLOCK(dn_clk),
      .LOAD_N(load_n), .MASTER_CLEAR(clear), .PRESET_INPUTS(preset),
      .COUNT_OUTPUTS(cnt), .CARRY_OUT_N(carry_n), .BORROW_OUT_N(borrow_n));

   // ==========================================================
   // Helpers
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Fixed wait: covers the synchroniser plus output register
   task automatic settle();
      repeat (4) @(negedge clk);
   endtask

   task automatic pulse(input bit up);
      udc_partner_inst.drive(up, 1'b0);
      settle();
      chk({3'h0, carry_n}, {3'h0, !(up && m == 15)});
      chk({3'h0, borrow_n}, {3'h0, !(!up && m == 0)});
      udc_partner_inst.drive(up, 1'b1);
      settle();
      m = up ? (m + 1) % 16 : (m + 15) % 16;
      chk(cnt, 4'(m));
   endtask

   task automatic load(input logic [3:0] v);
      preset = v;
      load_n = 1'b0;
      settle();
      m = v;
      chk(cnt, v);
      load_n = 1'b1;
      settle();
   endtask

   task automatic end_sim();
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk(cnt, 4'h0);
      load(4'he);
      repeat (3) pulse(1'b1);
      repeat (3) pulse(1'b0);
      // Clear beats load, down clock held low
      udc_partner_inst.drive(1'b0, 1'b0);
      preset = 4'h9;
      load_n = 1'b0;
      clear  = 1'b1;
      settle();
      m = 0;
      chk(cnt, 4'h0);
      chk({3'h0, borrow_n}, 4'h0);
      preset = 4'h0;
      settle();
      clear = 1'b0;
      settle();
      chk({3'h0, borrow_n}, 4'h0);
      load_n = 1'b1;
      settle();
      udc_partner_inst.drive(1'b0, 1'b1);
      settle();
      chk(cnt, 4'hf);
      // Load of fifteen with up clock low
      udc_partner_inst.drive(1'b1, 1'b0);
      load(4'hf);
      chk({3'h0, carry_n}, 4'h0);
      udc_partner_inst.drive(1'b1, 1'b1);
      settle();
      chk(cnt, 4'h0);
      m = 0;
      for (int i = 0; i < 40; i++) begin
         if ($random(seed) % 5 == 0) begin
            load(4'($random(seed)));
         end else begin
            pulse(1'($random(seed)));
         end
      end
      end_sim();
   end

   // Hang guard
   initial begin
      #2000000;
      n_fail++;
      end_sim();
   end
endmodule
